// ### test/ptlb_fabric_model.sv
// Purpose: Routing fabric around one block.
// Assumes: Fabric lines 15:12 carry the block's own outputs back.
// Notes:   The output routing stage is observed by the bench only.
`timescale 1ns/1ps
module ptlb_fabric_model (
  input  wire logic [11:0] drive,
  input  wire logic [3:0]  feedback,
  output logic      [15:0] fabric_in
);
  assign fabric_in = {feedback, drive};
endmodule // ptlb_fabric_model

// ### test/ptlb_logic_block_sva.sv
// Purpose: Concurrent checks on the ports of the product term logic block.
// Assumes: One clock domain; rst_b is synchronous and active low.
// Notes:   Register addresses from 0xB4 upward are unmapped.
`timescale 1ns/1ps
module ptlb_logic_block_sva (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] fabric_in,
  input wire logic [1:0]  dedicated_in,
  input wire logic        block_clock_zero,
  input wire logic        block_clock_one,
  input wire logic        block_clock_two,
  input wire logic [7:0]  cluster_oe_in,
  input wire logic [3:0]  block_out,
  input wire logic [3:0]  fabric_feedback,
  input wire logic [3:0]  output_routing_stage,
  input wire logic        shared_term_output_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // No write, no input and no clock change; nothing may move block_out.
  sequence quiet;
    !reg_wr && $stable(fabric_in) && $stable(dedicated_in)
      && $stable({block_clock_zero, block_clock_one, block_clock_two});
  endsequence
  AST_RST_OUT: assert property ($rose(rst_b) |-> block_out == 4'h0)
    else $error("outputs not cleared by reset");
  AST_RST_OE: assert property ($rose(rst_b) |-> !shared_term_output_enable)
    else $error("enable not cleared by reset");
  AST_FEEDBACK: assert property (fabric_feedback == block_out)
    else $error("feedback differs from output");
  AST_ROUTING: assert property (output_routing_stage == block_out)
    else $error("routing stage differs from output");
  AST_OE_LOW: assert property (cluster_oe_in == 8'h00 |=> !shared_term_output_enable)
    else $error("enable high with no term high");
  AST_HOLD: assert property (quiet [*3] |=> $stable(block_out))
    else $error("output moved without a cause");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_RD_UNMAP: assert property (reg_rd && reg_addr >= 8'hB4 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  C_CAPTURE: cover property ($rose(block_out[3]));
  C_OE: cover property ($rose(shared_term_output_enable));
  C_UNMAP: cover property (reg_rd && reg_addr >= 8'hB4);
endmodule // ptlb_logic_block_sva
bind ptlb_logic_block ptlb_logic_block_sva u_sva (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fabric_in(fabric_in), .dedicated_in(dedicated_in),
  .block_clock_zero(block_clock_zero), .block_clock_one(block_clock_one), .block_clock_two(block_clock_two),
  .cluster_oe_in(cluster_oe_in), .block_out(block_out), .fabric_feedback(fabric_feedback),
  .output_routing_stage(output_routing_stage), .shared_term_output_enable(shared_term_output_enable));

// ### test/ptlb_logic_block_tb_top.sv
// Purpose: Self-checking bench for the product term logic block.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes:   Plain sums run from a table; clocks, resets and enables follow by hand.
`timescale 1ns/1ps
`include "ptlb_regs.vh"
`define CHK(N,E,G) begin cmp_count++; if ((G) !== (E)) begin n_errors++; $display("wrong value %s exp %0h got %0h", N, E, G); end end
module ptlb_logic_block_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, oe;
  logic [11:0] drv = 12'h000;
  logic [1:0]  ded = 2'h0;
  logic [2:0]  bclk = 3'h0;
  logic [7:0]  oe_in = 8'h00;
  logic [15:0] fabric_in;
  logic [3:0]  block_out, fb, ors;
  // Each row is fabric byte, dedicated pins, expected outputs.
  logic [13:0] rows [6] = '{14'h0010, 14'h0051, 14'h00A2, 14'h0314, 14'h00F3, 14'h0347};
  int          n_errors = 0, cmp_count = 0;
  initial forever #12.5 clk = ~clk;
  ptlb_fabric_model u_fab (.drive(drv), .feedback(fb), .fabric_in(fabric_in));
  ptlb_logic_block u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fabric_in(fabric_in), .dedicated_in(ded), .block_clock_zero(bclk[0]),
    .block_clock_one(bclk[1]), .block_clock_two(bclk[2]), .cluster_oe_in(oe_in), .block_out(block_out),
    .fabric_feedback(fb), .output_routing_stage(ors), .shared_term_output_enable(oe));
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task set_in(input logic [11:0] f, input logic [1:0] d);
    @(posedge clk);
    drv <= f;
    ded <= d;
    wait_n(3);
  endtask
  task pulse(input logic [2:0] m);
    @(posedge clk);
    bclk <= m;
    repeat (2) @(posedge clk);
    bclk <= 3'h0;
    wait_n(3);
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(`PTLB_OFF_CTRL);
    `CHK("ctrl", `PTLB_CTRL_RESET, rd_val)
    wr(8'h00, 32'h00001);
    wr(8'h08, 32'h08000);
    wr(8'h24, 32'h10000);
    wr(8'h28, 32'h20002);
    wr(8'h40, 32'h0000C);
    wr(8'h60, 32'h00020);
    wr(8'h68, 32'h00010);
    wr(8'h98, 32'h00040);
    wr(`PTLB_OFF_OUT_CFG, 32'h03040908);
    wr(`PTLB_OFF_CTRL, 32'h1);
    rd(8'h28);
    `CHK("mask", 32'h20002, rd_val)
    rd(8'hFC);
    `CHK("unmapped", 32'h0, rd_val)
    for (int i = 0; i < 6; i++) begin
      set_in({4'h0, rows[i][13:6]}, rows[i][5:4]);
      `CHK("block_out", rows[i][3:0], block_out)
    end
    set_in(12'h010, 2'h1);
    pulse(3'h5);
    `CHK("other clocks", 4'h0, block_out)
    pulse(3'h2);
    `CHK("capture", 4'h9, block_out)
    wr(`PTLB_OFF_CTRL, 32'h5);
    set_in(12'h030, 2'h1);
    `CHK("term reset", 4'h0, block_out)
    set_in(12'h010, 2'h1);
    `CHK("held low", 4'h0, block_out)
    wr(`PTLB_OFF_CTRL, 32'h3);
    set_in(12'h030, 2'h1);
    `CHK("term clock", 4'h9, block_out)
    wr(`PTLB_OFF_OUT_CFG, 32'h0B040908);
    set_in(12'h040, 2'h1);
    `CHK("term19 sum", 4'h9, block_out)
    wr(`PTLB_OFF_OE_SEL, 32'h3);
    wr(`PTLB_OFF_CTRL, 32'h8);
    wait_n(3);
    `CHK("claimed", 4'h0, block_out)
    @(posedge clk) oe_in <= 8'h08;
    wait_n(1);
    `CHK("enable", 1'b1, oe)
    @(posedge clk) oe_in <= 8'hF7;
    wait_n(1);
    `CHK("enable off", 1'b0, oe)
    set_in(12'h050, 2'h1);
    `CHK("comb sum", 4'h9, block_out)
    wr(8'h88, 32'h00080);
    wr(`PTLB_OFF_OUT_CFG, 32'h040A9928);
    set_in(12'h02C, 2'h1);
    `CHK("xor sum", 4'h4, block_out)
    set_in(12'h020, 2'h1);
    `CHK("term12 moved", 4'h2, block_out)
    set_in(12'h080, 2'h1);
    `CHK("bypass out3", 4'h1, block_out)
    rd(`PTLB_OFF_STATUS);
    `CHK("status", 32'h00000081, rd_val)
    rd(`PTLB_OFF_IN_STAT);
    `CHK("terms", 32'h00020000, rd_val)
    @(posedge clk) oe_in <= 8'h08;
    @(posedge clk) rst_b <= 1'b0;
    wait_n(2);
    `CHK("reset out", 4'h0, block_out)
    `CHK("reset oe", 1'b0, oe)
    @(posedge clk) rst_b <= 1'b1;
    rd(`PTLB_OFF_OUT_CFG);
    `CHK("cfg cleared", 32'h0, rd_val)
    end_of_test;
  end
endmodule // ptlb_logic_block_tb_top

// ### verilog/ptlb_logic_block.v
// Purpose: One product term logic block with term sharing, registers and controls.
// Assumes: Inputs are synchronous to clk; block clocks are sampled on clk and act on their rising edge.
// Notes:   Configuration is loaded over the register port; rst_b is the chip reset pin.
// Behaviour
// - Block takes eighteen inputs: sixteen fabric, two dedicated pins.
// - Twenty product terms, each ANDs any true or complemented inputs.
// - Terms split into OR gates of four, four, five and seven.
// - Any gate reaches any output; gates may combine for wider sums.
// - Each output may use a fast bypass of four dedicated terms.
// - Bypass outputs are combinational only, no register.
// - Four D flip-flops with input XOR for logic, J-K or toggle.
// - Each output may bypass its register and show the sum.
// - Register outputs feed back to fabric and output routing stage.
// - Register clock picks one of three network clocks or a term.
// - Register reset is global reset OR optional term reset.
// - Active combined reset forces all register outputs to zero.
// - Terms claimed for clock, reset or enable leave all sums.
// - Term twelve: five-term gate normally, unused in bypass, four-term with XOR.
// - Unused term twelve may be block clock or local reset.
// - Cluster enable comes from term nineteen of any one selected block.
// - Dedicated pins reach only this cluster's blocks, unregistered.
// - Global reset comes from active-low chip reset pin to every register.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "ptlb_regs.vh"

module ptlb_logic_block (
  clk,
  rst_b,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  fabric_in,
  dedicated_in,
  block_clock_zero,
  block_clock_one,
  block_clock_two,
  cluster_oe_in,
  block_out,
  fabric_feedback,
  output_routing_stage,
  shared_term_output_enable
);
  input  wire                         clk;
  input  wire                         rst_b;
  input  wire [7:0]                   reg_addr;
  input  wire [31:0]                  reg_wdata;
  input  wire                         reg_wr;
  input  wire                         reg_rd;
  output reg  [31:0]                  reg_rdata;
  input  wire [`PTLB_NUM_FABRIC-1:0]  fabric_in;
  input  wire [`PTLB_NUM_DED-1:0]     dedicated_in;
  input  wire                         block_clock_zero;
  input  wire                         block_clock_one;
  input  wire                         block_clock_two;
  input  wire [`PTLB_NUM_BLK-1:0]     cluster_oe_in;
  output reg  [`PTLB_NUM_OUT-1:0]     block_out;
  output wire [`PTLB_NUM_OUT-1:0]     fabric_feedback;
  output wire [`PTLB_NUM_OUT-1:0]     output_routing_stage;
  output reg                          shared_term_output_enable;

  // Gate membership: gate0 = 0..3, gate1 = 4..7, gate2 = 8..12, gate3 = 13..19.
  localparam [`PTLB_NUM_PT-1:0] GATE0_MASK = 20'h0000F;
  localparam [`PTLB_NUM_PT-1:0] GATE1_MASK = 20'h000F0;
  localparam [`PTLB_NUM_PT-1:0] GATE2_MASK = 20'h01F00;
  localparam [`PTLB_NUM_PT-1:0] GATE3_MASK = 20'hFE000;

  reg  [`PTLB_NUM_PT*`PTLB_NUM_IN-1:0] true_mask;
  reg  [`PTLB_NUM_PT*`PTLB_NUM_IN-1:0] comp_mask;
  reg  [31:0]                          out_cfg;
  reg  [31:0]                          ctrl;
  reg  [2:0]                           oe_sel;
  reg  [`PTLB_NUM_OUT-1:0]             q;
  reg                                  clk_prev;
  reg  [`PTLB_NUM_OUT-1:0]             next_q;
  reg  [`PTLB_NUM_OUT-1:0]             next_out;
  reg  [`PTLB_NUM_OUT-1:0]             sum;
  reg  [`PTLB_NUM_PT-1:0]              live;
  reg                                  term_claimed;
  reg                                  xor_on_one;
  wire [`PTLB_NUM_IN-1:0]              in_vec;
  wire [`PTLB_NUM_PT-1:0]              terms;
  wire [3:0]                           gate_sum;
  wire [1:0]                           clk_sel;
  wire                                 sel_clk;
  wire                                 clk_rise;
  wire                                 term_reset;
  wire                                 comb_reset;

  // Returns gate g's term mask.
  function [`PTLB_NUM_PT-1:0] gate_mask;
    input [1:0] g;
    begin
      case (g)
        2'h0:    gate_mask = GATE0_MASK;
        2'h1:    gate_mask = GATE1_MASK;
        2'h2:    gate_mask = GATE2_MASK;
        default: gate_mask = GATE3_MASK;
      endcase
    end
  endfunction

  // Bypass terms of output o: four dedicated terms; term twelve is never one of them.
  function [`PTLB_NUM_PT-1:0] bypass_mask;
    input [1:0] o;
    begin
      case (o)
        2'h0:    bypass_mask = 20'h0000F;
        2'h1:    bypass_mask = 20'h000F0;
        2'h2:    bypass_mask = 20'h00F00;
        default: bypass_mask = 20'h1E000;
      endcase
    end
  endfunction

  // The two dedicated pins go straight into the array with no register.
  assign in_vec = {dedicated_in, fabric_in};

  ptlb_term_array u_terms (
    .in_vec    (in_vec),
    .true_mask (true_mask),
    .comp_mask (comp_mask),
    .terms     (terms)
  );

  assign clk_sel    = ctrl[`PTLB_CTRL_CLKSEL_HI:`PTLB_CTRL_CLKSEL_LO];

  always @* begin
    xor_on_one   = out_cfg[1*`PTLB_OCFG_W+4];
    // Term twelve is claimed for control whenever the term clock or the term reset is selected, and leaves every sum.
    term_claimed = (clk_sel == `PTLB_CLK_TERM) | ctrl[`PTLB_CTRL_ALT_RST];
    live         = terms;
    if (term_claimed) begin
      live[`PTLB_PT_ALT] = 1'b0;
    end
    if (ctrl[`PTLB_CTRL_OE_EN]) begin
      live[`PTLB_PT_OE] = 1'b0;
    end
  end

  // Term twelve moves from the five-term gate to the four-term gate in XOR mode on output one.
  assign gate_sum[0] = |(live & GATE0_MASK);
  assign gate_sum[1] = |(live & (GATE1_MASK | (xor_on_one ? 20'h01000 : 20'h00000)));
  assign gate_sum[2] = |(live & (GATE2_MASK & (xor_on_one ? 20'hFEFFF : 20'hFFFFF)));
  assign gate_sum[3] = |(live & GATE3_MASK);

  assign sel_clk = (clk_sel == `PTLB_CLK_ZERO) ? block_clock_zero :
                   (clk_sel == `PTLB_CLK_ONE)  ? block_clock_one  :
                   (clk_sel == `PTLB_CLK_TWO)  ? block_clock_two  :
                   terms[`PTLB_PT_ALT];
  assign clk_rise = sel_clk & ~clk_prev;

  assign term_reset = ctrl[`PTLB_CTRL_ALT_RST] & (clk_sel != `PTLB_CLK_TERM) & terms[`PTLB_PT_ALT];
  assign comb_reset = ~rst_b | term_reset;

  integer o;
  always @* begin
    next_q   = q;
    next_out = {`PTLB_NUM_OUT{1'b0}};
    sum      = {`PTLB_NUM_OUT{1'b0}};
    for (o = 0; o < `PTLB_NUM_OUT; o = o + 1) begin
      // Main sum: any gate to any output, optionally widened by the seven-term gate.
      sum[o] = gate_sum[out_cfg[o*`PTLB_OCFG_W +: 2]] | (out_cfg[o*`PTLB_OCFG_W+5] & gate_sum[3]);
      if (out_cfg[o*`PTLB_OCFG_W+4]) begin
        sum[o] = sum[o] ^ gate_sum[out_cfg[o*`PTLB_OCFG_W+6 +: 2]];
      end
      if (clk_rise) begin
        next_q[o] = sum[o];
      end
      // Reset wins over a capture in the same cycle, and an output in register mode sees it at once.
      if (comb_reset) begin
        next_q[o] = 1'b0;
      end
      if (out_cfg[o*`PTLB_OCFG_W+2]) begin
        next_out[o] = |(terms & bypass_mask(o[1:0]));
      end else if (out_cfg[o*`PTLB_OCFG_W+3]) begin
        next_out[o] = sum[o];
      end else begin
        next_out[o] = next_q[o];
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      q                         <= {`PTLB_NUM_OUT{1'b0}};
      clk_prev                  <= 1'b0;
      block_out                 <= {`PTLB_NUM_OUT{1'b0}};
      shared_term_output_enable <= 1'b0;
    end else begin
      q         <= next_q;
      clk_prev  <= sel_clk;
      block_out <= next_out;
      // The enable line of the cluster takes term nineteen of the selected block.
      shared_term_output_enable <= cluster_oe_in[oe_sel];
    end
  end

  // Registered outputs go both back to the fabric and to the output routing stage.
  assign fabric_feedback      = block_out;
  assign output_routing_stage = block_out;

  integer t;
  always @(posedge clk) begin
    if (!rst_b) begin
      true_mask <= {(`PTLB_NUM_PT*`PTLB_NUM_IN){1'b0}};
      comp_mask <= {(`PTLB_NUM_PT*`PTLB_NUM_IN){1'b0}};
      out_cfg   <= 32'h0000_0000;
      ctrl      <= `PTLB_CTRL_RESET;
      oe_sel    <= 3'h0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      for (t = 0; t < `PTLB_NUM_PT; t = t + 1) begin
        if (reg_wr && reg_addr == t * 8) begin
          true_mask[t*`PTLB_NUM_IN +: `PTLB_NUM_IN] <= reg_wdata[`PTLB_NUM_IN-1:0];
        end
        if (reg_wr && reg_addr == t * 8 + 4) begin
          comp_mask[t*`PTLB_NUM_IN +: `PTLB_NUM_IN] <= reg_wdata[`PTLB_NUM_IN-1:0];
        end
        if (reg_rd && reg_addr == t * 8) begin
          reg_rdata <= {14'h0000, true_mask[t*`PTLB_NUM_IN +: `PTLB_NUM_IN]};
        end
        if (reg_rd && reg_addr == t * 8 + 4) begin
          reg_rdata <= {14'h0000, comp_mask[t*`PTLB_NUM_IN +: `PTLB_NUM_IN]};
        end
      end
      if (reg_wr) begin
        case (reg_addr)
          `PTLB_OFF_OUT_CFG: out_cfg <= reg_wdata;
          `PTLB_OFF_CTRL:    ctrl    <= {28'h0000000, reg_wdata[3:0]};
          `PTLB_OFF_OE_SEL:  oe_sel  <= reg_wdata[2:0];
          default:           ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `PTLB_OFF_OUT_CFG: reg_rdata <= out_cfg;
          `PTLB_OFF_CTRL:    reg_rdata <= ctrl;
          `PTLB_OFF_OE_SEL:  reg_rdata <= {29'h00000000, oe_sel};
          `PTLB_OFF_STATUS:  reg_rdata <= {23'h000000, shared_term_output_enable, q, block_out};
          `PTLB_OFF_IN_STAT: reg_rdata <= {12'h000, terms};
          default:           ;
        endcase
      end
    end
  end

endmodule // ptlb_logic_block

// ### verilog/ptlb_regs.vh
// Purpose: Constants for the product term logic block.
// Assumes: Register bus word width of 32 bits; offsets are byte addresses.
// Notes:   Configuration registers steer the logic block; status registers read its state.
`ifndef PTLB_REGS_VH
`define PTLB_REGS_VH

`define PTLB_NUM_IN        18
`define PTLB_NUM_FABRIC    16
`define PTLB_NUM_DED       2
`define PTLB_NUM_PT        20
`define PTLB_NUM_OUT       4
`define PTLB_NUM_BLK       8

`define PTLB_PT_ALT        12
`define PTLB_PT_OE         19

// Per-term mask registers: term n at base + 8*n (true mask), base + 8*n + 4 (complement mask).
`define PTLB_OFF_TERM_BASE 8'h00
`define PTLB_OFF_OUT_CFG   8'hA0
`define PTLB_OFF_CTRL      8'hA4
`define PTLB_OFF_STATUS    8'hA8
`define PTLB_OFF_OE_SEL    8'hAC
`define PTLB_OFF_IN_STAT   8'hB0

// Per output in OUT_CFG, eight bits at 8*o: [1:0] gate select, [2] bypass4, [3] comb.
// Bits 7:4 of each byte: [4] xor mode, [5] add seven-term gate, [7:6] xor operand gate.
`define PTLB_OCFG_W        8

// CTRL fields.
`define PTLB_CTRL_CLKSEL_LO 0
`define PTLB_CTRL_CLKSEL_HI 1
`define PTLB_CTRL_ALT_RST   2
`define PTLB_CTRL_OE_EN     3
`define PTLB_CTRL_RESET     32'h0000_0000

`define PTLB_CLK_ZERO      2'h0
`define PTLB_CLK_ONE       2'h1
`define PTLB_CLK_TWO       2'h2
`define PTLB_CLK_TERM      2'h3

`endif

// ### verilog/ptlb_term_array.v
// Purpose: AND array of one logic block: twenty product terms over eighteen inputs.
// Assumes: Masks are held by the caller; a term with no inputs selected reads 0.
// Notes:   Each input may join a term in true form, complement form or not at all.
`timescale 1ns/1ps
`include "ptlb_regs.vh"

module ptlb_term_array (
  in_vec,
  true_mask,
  comp_mask,
  terms
);
  input  wire [`PTLB_NUM_IN-1:0]                in_vec;
  input  wire [`PTLB_NUM_PT*`PTLB_NUM_IN-1:0]   true_mask;
  input  wire [`PTLB_NUM_PT*`PTLB_NUM_IN-1:0]   comp_mask;
  output wire [`PTLB_NUM_PT-1:0]                terms;

  genvar t;
  generate
    for (t = 0; t < `PTLB_NUM_PT; t = t + 1) begin : g_term
      wire [`PTLB_NUM_IN-1:0] tm;
      wire [`PTLB_NUM_IN-1:0] cm;
      assign tm = true_mask[t*`PTLB_NUM_IN +: `PTLB_NUM_IN];
      assign cm = comp_mask[t*`PTLB_NUM_IN +: `PTLB_NUM_IN];
      // An unprogrammed term stays low so it never pollutes a sum.
      assign terms[t] = (|(tm | cm)) & (&((in_vec | ~tm) & (~in_vec | ~cm)));
    end
  endgenerate
endmodule // ptlb_term_array
